//--- src/lpddr_burst_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - After burst stop on a write, data capture ends WL clocks later.
// - After burst stop on a read, data output ends RL clocks later.
// - One write mask per data byte blocks that byte on any beat.
// - Write masks sampled with identical timing to write data.
// - Precharge decodes as chip select low, bits 0..3 high high low high.
// - All-bank flag closes every bank; else bits 9..7 pick one bank.
// - Four-bank device ignores top bank bit, codes 4..7 alias 0..3.
// - Array write starts only after all four beats of a group latched.
// - Auto precharge bit low leaves the bank open after the burst.
// - Auto precharge bit is falling-edge bit 0; high engages auto precharge.
// - Read auto precharge starts at max of half burst, half burst-2+RTP.
// - Burst stop decodes as chip select low, bits 0..3 high high low low.
// - Write auto precharge starts one clock plus recovery time after write burst completes.
module lpddr_burst_ctrl
    import lpddr_cmd_pkg::*;
#(
    parameter int DQ_BYTES = 2,
    parameter int EIGHT_BANK = 1,
    parameter int BURST_LEN = BURST_LEN_DEF,
    parameter int READ_LAT = READ_LAT_DEF,
    parameter int WRITE_LAT = WRITE_LAT_DEF,
    parameter int RTP_CLK = RTP_CLK_DEF,
    parameter int WR_CLK = WR_CLK_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link pins, inputs asynchronous to core_clk
    input wire logic link_clk,
    input wire logic cs_n,
    input wire logic [9:0] ca,
    input wire logic [DQ_BYTES*8-1:0] dq_in,
    input wire logic [DQ_BYTES-1:0] write_byte_mask,
    output logic [DQ_BYTES*8-1:0] dq_out,
    output logic dq_oe,
    // Array side
    input wire logic [7:0] bank_activate,
    output logic [7:0] bank_open,
    output logic array_write,
    output logic [DQ_BYTES*32-1:0] array_wdata,
    output logic [DQ_BYTES*4-1:0] array_wkeep,
    output logic precharge_pulse
);
    localparam int W = DQ_BYTES * 8;
    localparam int HALF = BURST_LEN / 2;
    localparam int RD_AP_A = HALF;
    localparam int RD_AP_B = HALF - 2 + RTP_CLK;
    localparam int RD_AP = (RD_AP_A > RD_AP_B) ? RD_AP_A : RD_AP_B;
    localparam int WR_AP = WRITE_LAT + HALF + WR_CLK + 1;

    typedef enum {IDLE, RD_BURST, WR_BURST} burst_state_t;
    burst_state_t state;

    // Two-flop synchronisers; first stage is read only by the second.
    logic clk_meta;
    logic clk_s, clk_d;
    logic cs_meta, cs_s;
    logic [9:0] ca_meta, ca_s;
    logic [W-1:0] dq_meta, dq_s;
    logic [DQ_BYTES-1:0] dm_meta, dm_s;
    always_ff @(posedge core_clk) begin
        clk_meta <= link_clk;
        clk_s <= clk_meta;
        clk_d <= clk_s;
        cs_meta <= cs_n;
        cs_s <= cs_meta;
        ca_meta <= ca;
        ca_s <= ca_meta;
        dq_meta <= dq_in;
        dq_s <= dq_meta;
        dm_meta <= write_byte_mask;
        dm_s <= dm_meta;
    end
    wire rise = clk_s && !clk_d;
    wire fall = !clk_s && clk_d;

    // Rising-edge command capture; falling-edge bit completes it.
    logic cs_r;
    logic [9:0] ca_r;
    logic pend;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pend <= 1'b0;
            cs_r <= 1'b1;
            ca_r <= '0;
        end else if (rise) begin
            cs_r <= cs_s;
            ca_r <= ca_s;
            pend <= !cs_s;
        end else if (fall) begin
            pend <= 1'b0;
        end
    end
    wire cmd_ok = fall && pend;
    wire is_pre = cmd_ok && (ca_r[3:0] == CMD_PRECHARGE);
    wire is_bst = cmd_ok && (ca_r[3:0] == CMD_BURST_STOP);
    wire is_rd = cmd_ok && (ca_r[2:0] == CMD_READ_CODE);
    wire is_wr = cmd_ok && (ca_r[2:0] == CMD_WRITE_CODE);
    wire ap_bit = ca_s[AUTO_PRE_POS];

    // Burst tracking counted in link clock rising edges.
    logic [7:0] cyc;
    logic [7:0] end_cyc;
    logic [7:0] lat_left;
    logic [2:0] bank;
    logic [2:0] cmd_bank;
    logic stopped;
    logic [7:0] ap_cnt;
    always_comb begin
        cmd_bank = ca_r[BANK_LSB_POS +: 3];
        if (EIGHT_BANK == 0) begin
            cmd_bank[2] = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= IDLE;
            cyc <= '0;
            end_cyc <= '0;
            bank <= '0;
            stopped <= 1'b0;
        end else if (is_rd || is_wr) begin
            state <= is_rd ? RD_BURST : WR_BURST;
            cyc <= '0;
            end_cyc <= 8'(HALF);
            bank <= cmd_bank;
            stopped <= 1'b0;
        end else if (is_bst && !stopped && state != IDLE) begin
            // Effective length becomes twice the elapsed clocks.
            end_cyc <= cyc;
            stopped <= 1'b1;
        end else if (rise) begin
            case (state)
                RD_BURST, WR_BURST: begin
                    cyc <= cyc + 8'h01;
                    if (cyc + 8'h01 >= end_cyc + 8'(state == WR_BURST ? WRITE_LAT : READ_LAT)) begin
                        state <= IDLE;
                    end
                end
                default: state <= IDLE;
            endcase
        end
    end

    // Auto precharge counts link clock rises from the command itself, so a read
    // precharge can start under the tail of its own data burst.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ap_cnt <= '0;
        end else if ((is_rd || is_wr) && !ap_bit) begin
            ap_cnt <= '0;
        end else if (is_rd) begin
            ap_cnt <= 8'(RD_AP);
        end else if (is_wr) begin
            ap_cnt <= 8'(WR_AP);
        end else if (rise && ap_cnt != 8'h00) begin
            ap_cnt <= ap_cnt - 8'h01;
        end
    end
    wire ap_fire = rise && ap_cnt == 8'h01;
    // Data windows open once latency has passed; write beats run two per link clock.
    wire rd_live = state == RD_BURST && cyc >= 8'(READ_LAT);
    wire wr_live = state == WR_BURST && cyc >= 8'(WRITE_LAT);

    // Bank open state.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bank_open <= BANKS_RESET;
            precharge_pulse <= 1'b0;
        end else begin
            precharge_pulse <= is_pre || ap_fire;
            if (is_pre && ca_r[ALL_BANK_POS]) begin
                bank_open <= BANKS_RESET;
            end else if (is_pre) begin
                bank_open <= (bank_open | bank_activate) & ~(8'h01 << cmd_bank);
            end else if (ap_fire) begin
                bank_open <= (bank_open | bank_activate) & ~(8'h01 << bank);
            end else begin
                bank_open <= bank_open | bank_activate;
            end
        end
    end

    // Write capture on both link edges, mask sampled alongside data.
    logic [1:0] beat;
    logic [W*4-1:0] grp;
    logic [DQ_BYTES*4-1:0] keep;
    always_ff @(posedge core_clk) begin
        if (!rst_n || is_wr) begin
            beat <= '0;
            array_write <= 1'b0;
            grp <= '0;
            keep <= '0;
            array_wdata <= '0;
            array_wkeep <= '0;
        end else begin
            array_write <= 1'b0;
            if (wr_live && (rise || fall)) begin
                grp[beat*W +: W] <= dq_s;
                keep[beat*DQ_BYTES +: DQ_BYTES] <= ~dm_s;
                beat <= beat + 2'h1;
                if (beat == 2'(PREFETCH_BEATS - 1)) begin
                    array_write <= 1'b1;
                    array_wdata <= {dq_s, grp[W*3-1:0]};
                    array_wkeep <= {~dm_s, keep[DQ_BYTES*3-1:0]};
                end
            end
        end
    end

    // Read output from a small store of the last written group.
    logic [W-1:0] rd_word;
    beat_store #(.WIDTH(W), .DEPTH(4)) u_store (
        .core_clk(core_clk),
        .wr_en(wr_live && (rise || fall)),
        .wr_addr(beat),
        .wr_data(dq_s),
        .wr_keep(~dm_s),
        .rd_addr(beat),
        .rd_data(rd_word)
    );
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            dq_oe <= rd_live;
            dq_out <= rd_live ? rd_word : '0;
        end
    end
endmodule : lpddr_burst_ctrl

//--- src/lpddr_cmd_pkg.sv
package lpddr_cmd_pkg;
    // Rising-edge command codes on command bits 3..0; read and write use bits 2..0.
    localparam logic [3:0] CMD_PRECHARGE = 4'hB;
    localparam logic [3:0] CMD_BURST_STOP = 4'h3;
    localparam logic [2:0] CMD_READ_CODE = 3'h5;
    localparam logic [2:0] CMD_WRITE_CODE = 3'h1;
    // Field positions in the rising-edge command word.
    localparam int ALL_BANK_POS = 4;
    localparam int BANK_LSB_POS = 7;
    // Auto precharge sits on falling-edge bit 0.
    localparam int AUTO_PRE_POS = 0;
    localparam int PREFETCH_BEATS = 4;
    // Timing in cycles of the link clock; burst length in data beats.
    localparam int READ_LAT_DEF = 3;
    localparam int WRITE_LAT_DEF = 1;
    localparam int BURST_LEN_DEF = 8;
    localparam int RTP_CLK_DEF = 2;
    localparam int WR_CLK_DEF = 3;
    localparam logic [7:0] BANKS_RESET = 8'h00;
endpackage : lpddr_cmd_pkg

//--- src/beat_store.sv
`timescale 1ns/1ps
module beat_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // Clock
    input wire logic core_clk,
    // Write port
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [WIDTH/8-1:0] wr_keep,
    // Read port
    input wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    // One generate lane per byte so a masked byte keeps its old contents.
    for (genvar b = 0; b < WIDTH / 8; b++) begin : g_lane
        always_ff @(posedge core_clk) begin
            if (wr_en && wr_keep[b]) begin
                mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data <= mem[rd_addr];
    end
endmodule : beat_store

//--- bench/lpddr_burst_ctrl_asserts.sv
`timescale 1ns/1ps
module lpddr_burst_ctrl_asserts #(
    parameter int EIGHT_BANK = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Watched ports
    input wire logic [7:0] bank_activate,
    input wire logic [7:0] bank_open,
    input wire logic array_write,
    input wire logic dq_oe,
    input wire logic precharge_pulse
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_aw_quiet;
        !array_write [*8];
    endsequence
    sequence s_oe_held;
        dq_oe [*8];
    endsequence
    property p_pulse_gap;
        precharge_pulse |=> !precharge_pulse [*7];
    endproperty
    a_pulse_gap: assert property (p_pulse_gap) else $error("precharge pulse gap");
    property p_close_pulse;
        (($past(bank_open) & ~bank_open) != 8'h00) |-> precharge_pulse;
    endproperty
    a_close_pulse: assert property (p_close_pulse) else $error("close without pulse");
    property p_alias;
        (EIGHT_BANK == 0) |-> ((($past(bank_open[7:4]) & ~bank_open[7:4])
            & ~($past(bank_open[3:0]) & ~bank_open[3:0])) == 4'h0);
    endproperty
    a_alias: assert property (p_alias) else $error("upper bank closed alone");
    property p_aw_group;
        array_write |=> s_aw_quiet;
    endproperty
    a_aw_group: assert property (p_aw_group) else $error("array write too soon");
    property p_oe_burst;
        $rose(dq_oe) |-> s_oe_held;
    endproperty
    a_oe_burst: assert property (p_oe_burst) else $error("read burst cut short");
    property p_act_keep;
        (bank_activate != 8'h00) |=> (precharge_pulse
            || ((bank_open & $past(bank_activate)) == $past(bank_activate)));
    endproperty
    a_act_keep: assert property (p_act_keep) else $error("bank not opened");
    property p_no_self_open;
        (bank_activate == 8'h00) |=> ((bank_open & ~$past(bank_open)) == 8'h00);
    endproperty
    a_no_self_open: assert property (p_no_self_open) else $error("bank opened alone");
    property p_reset_clear;
        $rose(rst_n) |-> (bank_open == 8'h00) && !precharge_pulse && !array_write;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("not clear after reset");
endmodule : lpddr_burst_ctrl_asserts
bind lpddr_burst_ctrl lpddr_burst_ctrl_asserts #(.EIGHT_BANK(EIGHT_BANK))
    i_lpddr_burst_ctrl_asserts (.core_clk, .rst_n, .bank_activate, .bank_open,
    .array_write, .dq_oe, .precharge_pulse);

//--- bench/lpddr_host_model.sv
`timescale 1ns/1ps
module lpddr_host_model (
    // Link clock and command
    output logic link_clk,
    output logic cs_n,
    output logic [9:0] ca,
    // Write data
    output logic [15:0] dq_in,
    output logic [1:0] write_byte_mask
);
    // The memory clock runs free; the offset keeps it out of step with core_clk.
    initial begin
        link_clk = 1'b0;
        cs_n = 1'b1;
        ca = 10'h000;
        dq_in = 16'h0000;
        write_byte_mask = 2'b00;
        #7;
        forever #160 link_clk = ~link_clk;
    end
    task automatic send(input logic [9:0] rise_ca, input logic [9:0] fall_ca);
        @(negedge link_clk);
        cs_n <= 1'b0;
        ca <= rise_ca;
        // Each half of the command stands well past its edge, since the pins are
        // sampled through the same two flops as the link clock itself.
        @(posedge link_clk);
        #80;
        ca <= fall_ca;
        @(negedge link_clk);
        #80;
        cs_n <= 1'b1;
        ca <= ~fall_ca;
    endtask : send
    // Each beat stands 40 ns before to 120 ns after its edge, so a capture delayed
    // by the synchroniser still sees it; the first beat meets the falling edge
    // one link clock after the command, where capture begins.
    task automatic write_beats(input logic [127:0] data, input logic [15:0] mask);
        @(posedge link_clk);
        #120;
        for (int i = 0; i < 8; i++) begin
            dq_in = data[16*i +: 16];
            write_byte_mask = mask[2*i +: 2];
            @(link_clk);
            #120;
        end
        dq_in = ~dq_in;
        write_byte_mask = ~write_byte_mask;
    endtask : write_beats
endmodule : lpddr_host_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
    import lpddr_cmd_pkg::*;
    typedef struct packed {
        logic [9:0] cmd;
        logic [7:0] open_after;
        logic [7:0] open_quad;
    } pre_row_t;
    logic core_clk, rst_n, link_clk, cs_n, array_write, precharge_pulse, dq_oe;
    logic [9:0] ca;
    logic [15:0] dq_in;
    logic [1:0] write_byte_mask;
    logic [7:0] bank_activate, bank_open, array_wkeep, bank_open_quad;
    logic [63:0] array_wdata;
    logic [71:0] aw_q[$];
    int fails, compares, n, oe_n;
    pre_row_t rows [9] = '{'{10'h00B, 8'hFE, 8'hFE}, '{10'h08B, 8'hFD, 8'hFD},
        '{10'h10B, 8'hFB, 8'hFB}, '{10'h18B, 8'hF7, 8'hF7}, '{10'h20B, 8'hEF, 8'hFE},
        '{10'h28B, 8'hDF, 8'hFD}, '{10'h30B, 8'hBF, 8'hFB}, '{10'h38B, 8'h7F, 8'hF7},
        '{10'h29B, 8'h00, 8'h00}};
    lpddr_host_model i_lpddr_host_model (.link_clk, .cs_n, .ca, .dq_in, .write_byte_mask);
    lpddr_burst_ctrl i_lpddr_burst_ctrl (.core_clk, .rst_n, .link_clk, .cs_n, .ca, .dq_in,
        .write_byte_mask, .dq_out(), .dq_oe, .bank_activate, .bank_open, .array_write,
        .array_wdata, .array_wkeep, .precharge_pulse);
    // A four-bank build on the same pins shows the bank code aliasing.
    lpddr_burst_ctrl #(.EIGHT_BANK(0)) i_lpddr_burst_ctrl_quad (.core_clk, .rst_n, .link_clk,
        .cs_n, .ca, .dq_in, .write_byte_mask, .dq_out(), .dq_oe(), .bank_activate,
        .bank_open(bank_open_quad), .array_write(), .array_wdata(), .array_wkeep(),
        .precharge_pulse());
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge core_clk) begin
        if (array_write === 1'b1) begin
            aw_q.push_back({array_wkeep, array_wdata});
        end
    end
    task automatic summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic check(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic open_all;
        repeat (16) @(negedge core_clk);
        bank_activate = 8'hFF;
        @(negedge core_clk);
        bank_activate = 8'h00;
        repeat (16) @(negedge core_clk);
    endtask : open_all
    task automatic wait_pulse(output int cnt);
        cnt = 0;
        while (precharge_pulse !== 1'b1) begin
            @(negedge core_clk);
            cnt++;
            if (cnt > 200) begin
                fails++;
                summarize();
            end
        end
    endtask : wait_pulse
    initial begin
        rst_n = 1'b0;
        bank_activate = 8'h00;
        repeat (10) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        foreach (rows[i]) begin
            open_all();
            i_lpddr_host_model.send(rows[i].cmd, 10'h000);
            wait_pulse(n);
            check(72'(bank_open), 72'(rows[i].open_after));
            check(72'(bank_open_quad), 72'(rows[i].open_quad));
        end
        $display("bank select done");
        open_all();
        i_lpddr_host_model.send(10'h105, 10'h001);
        wait_pulse(n);
        check(72'(n >= 20 && n <= 44), 72'h1);
        check(72'(bank_open), 72'hFB);
        open_all();
        i_lpddr_host_model.send(10'h185, 10'h000);
        n = 0;
        oe_n = 0;
        repeat (80) begin
            @(negedge core_clk);
            n += int'(precharge_pulse !== 1'b0);
            oe_n += int'(dq_oe === 1'b1);
        end
        check(72'(n), 72'h0);
        check(72'(oe_n), 72'h20);
        check(72'(bank_open), 72'hFF);
        $display("auto precharge done");
        aw_q.delete();
        i_lpddr_host_model.send(10'h001, 10'h000);
        i_lpddr_host_model.write_beats(128'h8888_7777_6666_5555_4444_3333_2222_1111, 16'h2004);
        repeat (40) @(negedge core_clk);
        check(72'(aw_q.size()), 72'h2);
        check(aw_q[0], {8'hFB, 64'h4444_3333_2222_1111});
        check(aw_q[1], {8'hDF, 64'h8888_7777_6666_5555});
        $display("write mask done");
        aw_q.delete();
        i_lpddr_host_model.send(10'h001, 10'h000);
        fork
            i_lpddr_host_model.write_beats(128'h0, 16'h0000);
            i_lpddr_host_model.send(10'h003, 10'h000);
        join
        repeat (40) @(negedge core_clk);
        check(72'(aw_q.size()), 72'h1);
        $display("burst stop done");
        open_all();
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        check(72'(bank_open), 72'h0);
        rst_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check(72'(bank_open), 72'h0);
        $display("reset done");
        summarize();
    end
endmodule : tb
